/* File: shared/nsp_pkg.sv */
package nsp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_PASS = 8'h00;
	localparam logic [7:0] OFS_IMOT = 8'h04;
	localparam logic [7:0] OFS_GROUP = 8'h08;
	localparam logic [7:0] OFS_FORCE = 8'h0C;
	localparam logic [7:0] OFS_CLEAR = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_UNB_CNT = 8'h18;
	localparam logic [7:0] OFS_REV_CNT = 8'h1C;
	localparam logic [7:0] OFS_REV_MEAS = 8'h20;
	localparam logic [7:0] OFS_UNB_MEAS = 8'h24;
	localparam logic [7:0] OFS_REC_SEL = 8'h2C;
	localparam logic [7:0] OFS_REC_VAL = 8'h30;
	localparam logic [7:0] OFS_REC_DATE = 8'h34;
	localparam logic [7:0] OFS_REC_TOD = 8'h38;
	localparam logic [7:0] OFS_GRP_BASE = 8'h40;
	// Group select source kinds
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_DIGITAL = 3'h1;
	localparam logic [2:0] SRC_VIRT_IN = 3'h2;
	localparam logic [2:0] SRC_INDICATOR = 3'h3;
	localparam logic [2:0] SRC_VIRT_OUT = 3'h4;
	// Reset values
	localparam logic [15:0] RST_IMOT = 16'h0064;
	localparam logic [15:0] RST_PICKUP_PCT = 16'h000F;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int FORCE_TIMEOUT_MIN = 5;
	localparam int FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60_000;
	localparam int MAX_DELAY_S = 1000;
	localparam logic [31:0] MAX_DELAY_MS = 32'(MAX_DELAY_S * 1000);
	localparam logic [19:0] REV_DELAY_MS = 20'h00064;
	localparam logic [15:0] REV_RATIO_PCT = 16'h0050;
	localparam logic [31:0] REV_AVG_TENTHS = 32'h0000_0002;
	localparam logic [31:0] PCT_FULL = 32'h0000_0064;
	// Password key; the value is arbitrary
	localparam logic [31:0] PASS_KEY = 32'h0000_5A3C;

	typedef struct packed {
		logic [15:0] pickup;
		logic inverse_delay_mode;
		logic [19:0] fixed_ms;
		logic [19:0] delay_multiplier;
	} group_set_t;

	typedef struct packed {
		logic [15:0] max_val;
		logic [7:0] edly;
		logic [1:0] grp;
		logic [31:0] date;
		logic [31:0] tod;
	} fault_rec_t;

	typedef struct packed {
		logic [15:0] i2;
		logic [15:0] i1;
		logic [15:0] iavg;
		logic valid;
	} seq_meas_t;

	typedef struct packed {
		logic start;
		logic trip;
	} stage_out_t;
endpackage

/* File: logic/negative_sequence_protection.sv */
module negative_sequence_protection
	import nsp_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int FORCE_MS = FORCE_TIMEOUT_MS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire seq_meas_t meas,
	input wire logic motor_starting,
	input wire logic block_unb,
	input wire logic block_rev,
	input wire logic [7:0] digital_in,
	input wire logic [7:0] virtual_input_n,
	input wire logic [7:0] indicator_signal_n,
	input wire logic [7:0] virtual_output_n,
	input wire logic [31:0] date_stamp,
	input wire logic [31:0] time_of_day_ms,
	output stage_out_t unb_out,
	output stage_out_t rev_out,
	output logic force_flag
);
	// Every piece of state lives here so that one register holds it all
	typedef struct packed {
		logic [7:0] din1;
		logic [7:0] din2;
		logic [7:0] din3;
		logic [7:0] din_f;
		logic [15:0] tick_cnt;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
		logic unlocked;
		logic [15:0] imot;
		logic [1:0] grp_man;
		logic [1:0] grp_alt;
		logic [2:0] src_kind;
		logic [2:0] src_idx;
		group_set_t [3:0] grp;
		logic force_on;
		logic [19:0] force_ms;
		logic [3:0] fbits;
		logic [15:0] unb_pct;
		logic [15:0] rev_pct;
		logic iavg_ok;
		logic [1:0] act_grp;
		logic unb_st;
		logic unb_tr;
		logic [19:0] unb_el;
		logic [7:0] unb_edly;
		logic [15:0] unb_max;
		logic [15:0] unb_scnt;
		logic [15:0] unb_tcnt;
		logic rev_st;
		logic rev_tr;
		logic [19:0] rev_el;
		logic [7:0] rev_edly;
		logic [15:0] rev_max;
		logic [15:0] rev_scnt;
		logic [15:0] rev_tcnt;
		logic [2:0] wptr;
		logic [2:0] rec_sel;
		fault_rec_t [7:0] rec;
		logic unb_so;
		logic unb_to;
		logic rev_so;
		logic rev_to;
	} st_t;

	// Present state, its next value and the helpers settled anew each cycle
	st_t s;
	st_t n;
	logic tick;
	logic [7:0] agree;
	logic src_bit;
	group_set_t g;
	logic [31:0] u_sq;
	logic [31:0] p_sq;
	logic [47:0] inv_t;
	logic [31:0] target;
	logic unb_raw;
	logic rev_raw;
	logic [2:0] rd_idx;
	fault_rec_t rr;
	logic [1:0] wg;

	// Group settings occupy the window above the fixed registers
	function automatic logic is_grp(input logic [7:0] a);
		return a >= OFS_GRP_BASE && a < 8'h80;
	endfunction

	// Percent of a over b, saturated; zero divisor gives zero
	function automatic logic [15:0] pct(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] q;
		q = 32'h0000_0000;
		if (b != 16'h0000) begin
			q = ({16'h0000, a} * PCT_FULL) / {16'h0000, b};
		end
		return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
	endfunction

	// Elapsed as percent of target, capped at full scale
	function automatic logic [7:0] edly_of(input logic [19:0] el, input logic [31:0] tg);
		logic [31:0] q;
		q = PCT_FULL;
		if (tg != 32'h0000_0000) begin
			q = ({12'h000, el} * PCT_FULL) / tg;
		end
		return (q > PCT_FULL) ? PCT_FULL[7:0] : q[7:0];
	endfunction

	// Outputs straight from the state register; the response never signals an error
	assign hreadyout = !s.rd_pend;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign unb_out.start = s.unb_so;
	assign unb_out.trip = s.unb_to;
	assign rev_out.start = s.rev_so;
	assign rev_out.trip = s.rev_to;
	assign force_flag = s.force_on;

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		// Group index defaults to zero so that no path leaves it held
		wg = 2'h0;
		// Pin inputs: a change counts once stages two and three agree
		n.din1 = digital_in;
		n.din2 = s.din1;
		n.din3 = s.din2;
		agree = ~(s.din2 ^ s.din3);
		n.din_f = (s.din2 & agree) | (s.din_f & ~agree);

		// Millisecond tick from the bus clock
		tick = (s.tick_cnt == 16'(TICK_CYC - 1));
		n.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

		// Sequence quantities are taken from the fundamental only
		if (meas.valid) begin
			n.unb_pct = pct(meas.i2, s.imot);
			n.rev_pct = pct(meas.i2, meas.i1);
			// Average above 0.2 of nominal, kept in integers as iavg*10 > imot*2
			n.iavg_ok = ({16'h0000, meas.iavg} * 32'h0000_000A) >
				({16'h0000, s.imot} * REV_AVG_TENTHS);
		end

		// Active group: manual choice, alternate while the chosen signal is high
		case (s.src_kind)
			SRC_NONE: src_bit = 1'b0;
			SRC_DIGITAL: src_bit = s.din_f[s.src_idx];
			SRC_VIRT_IN: src_bit = virtual_input_n[s.src_idx];
			SRC_INDICATOR: src_bit = indicator_signal_n[s.src_idx];
			SRC_VIRT_OUT: src_bit = virtual_output_n[s.src_idx];
			default: src_bit = 1'b0;
		endcase
		n.act_grp = src_bit ? s.grp_alt : s.grp_man;
		// Settings of whichever group is active this cycle
		g = s.grp[s.act_grp];

		// Delay target in ms; a zero denominator cannot occur while started
		// Ratios are in percent, so the squares carry a factor of 10000
		u_sq = {16'h0000, s.unb_pct} * {16'h0000, s.unb_pct};
		p_sq = {16'h0000, g.pickup} * {16'h0000, g.pickup};
		inv_t = 48'h0000_0000_0000;
		if (u_sq > p_sq) begin
			inv_t = ({28'h000_0000, g.delay_multiplier} * 48'h0000_0000_2710) /
				{16'h0000, u_sq - p_sq};
		end
		if (g.inverse_delay_mode) begin
			target = (inv_t > {16'h0000, MAX_DELAY_MS}) ? MAX_DELAY_MS : inv_t[31:0];
		end else begin
			target = {12'h000, g.fixed_ms};
		end

		// Unbalance stage timing; drop below pick-up resets the timer
		unb_raw = (s.unb_pct > g.pickup) && !block_unb;
		if (unb_raw) begin
			if (tick && {12'h000, s.unb_el} < target) begin
				n.unb_el = s.unb_el + 20'h00001;
			end
			n.unb_tr = {12'h000, s.unb_el} >= target;
			// The timer stops at the target, so a tripped stage shows 100
			n.unb_edly = edly_of(s.unb_el, target);
			n.unb_max = (s.unb_st && s.unb_max > s.unb_pct) ? s.unb_max : s.unb_pct;
		end else begin
			n.unb_el = 20'h00000;
			n.unb_tr = 1'b0;
		end
		n.unb_st = unb_raw;

		// Reversal stage: only meaningful during motor start-up
		// Its delay is fixed, so no setting group takes part
		rev_raw = motor_starting && (s.rev_pct > REV_RATIO_PCT) && s.iavg_ok && !block_rev;
		if (rev_raw) begin
			if (tick && s.rev_el < REV_DELAY_MS) begin
				n.rev_el = s.rev_el + 20'h00001;
			end
			n.rev_tr = s.rev_el >= REV_DELAY_MS;
			n.rev_edly = edly_of(s.rev_el, {12'h000, REV_DELAY_MS});
			n.rev_max = (s.rev_st && s.rev_max > s.rev_pct) ? s.rev_max : s.rev_pct;
		end else begin
			n.rev_el = 20'h00000;
			n.rev_tr = 1'b0;
		end
		n.rev_st = rev_raw;

		// Record a fault when the unbalance start drops, overwriting the oldest
		if (s.unb_st && !unb_raw) begin
			n.rec[s.wptr].max_val = s.unb_max;
			n.rec[s.wptr].edly = s.unb_edly;
			n.rec[s.wptr].grp = s.act_grp;
			n.rec[s.wptr].date = date_stamp;
			n.rec[s.wptr].tod = time_of_day_ms;
			// Pointer wraps at eight, so the ninth fault replaces the first
			n.wptr = s.wptr + 3'h1;
		end

		// Force timeout, counted in ms ticks
		// An unlocked force write restarts the count, so a test can be extended
		if (s.force_on && tick) begin
			n.force_ms = s.force_ms + 20'h00001;
			if (s.force_ms == 20'(FORCE_MS - 1)) begin
				n.force_on = 1'b0;
				n.fbits = 4'h0;
			end
		end

		// Bus data phase of a write
		if (s.wr_pend) begin
			case (s.addr)
				OFS_PASS: n.unlocked = (hwdata == PASS_KEY);
				OFS_IMOT: if (s.unlocked) begin
					n.imot = hwdata[15:0];
				end
				OFS_GROUP: if (s.unlocked) begin
					n.grp_man = hwdata[1:0];
					n.grp_alt = hwdata[3:2];
					n.src_kind = hwdata[6:4];
					n.src_idx = hwdata[9:7];
				end
				OFS_FORCE: begin
					// Force bits need force already on; the same write does not enable them
					if (s.force_on) begin
						n.fbits = hwdata[4:1];
					end
					if (s.unlocked) begin
						n.force_on = hwdata[0];
						n.force_ms = 20'h00000;
						if (!hwdata[0]) begin
							n.fbits = 4'h0;
						end
					end
				end
				OFS_CLEAR: begin
					// Counter clears need no password
					if (hwdata[0]) begin
						n.unb_scnt = 16'h0000;
						n.unb_tcnt = 16'h0000;
					end
					if (hwdata[1]) begin
						n.rev_scnt = 16'h0000;
						n.rev_tcnt = 16'h0000;
					end
				end
				OFS_REC_SEL: n.rec_sel = hwdata[2:0];
				// Group window: address bits 5:4 pick the group, bits 3:2 the word
				default: if (is_grp(s.addr) && s.unlocked) begin
					wg = s.addr[5:4];
					case (s.addr[3:2])
						2'h0: begin
							n.grp[wg].pickup = hwdata[15:0];
							n.grp[wg].inverse_delay_mode = hwdata[16];
						end
						2'h1: n.grp[wg].fixed_ms = hwdata[19:0];
						2'h2: n.grp[wg].delay_multiplier = hwdata[19:0];
						default: n.grp[wg].pickup = s.grp[wg].pickup;
					endcase
				end
			endcase
		end

		// Outputs: forcing replaces live status, blocking masks both
		n.unb_so = !block_unb && (n.force_on ? n.fbits[0] : n.unb_st);
		n.unb_to = !block_unb && (n.force_on ? n.fbits[1] : n.unb_tr);
		n.rev_so = !block_rev && (n.force_on ? n.fbits[2] : n.rev_st);
		n.rev_to = !block_rev && (n.force_on ? n.fbits[3] : n.rev_tr);

		// Counters count rising outputs; placed after the clear so a count wins
		// Counts wrap at 16 bits rather than stick at full scale
		if (n.unb_so && !s.unb_so) begin
			n.unb_scnt = n.unb_scnt + 16'h0001;
		end
		if (n.unb_to && !s.unb_to) begin
			n.unb_tcnt = n.unb_tcnt + 16'h0001;
		end
		if (n.rev_so && !s.rev_so) begin
			n.rev_scnt = n.rev_scnt + 16'h0001;
		end
		if (n.rev_to && !s.rev_to) begin
			n.rev_tcnt = n.rev_tcnt + 16'h0001;
		end

		// Read data is built in the wait cycle so it sees any write just landed
		// Newest record sits just below the write pointer
		rd_idx = s.wptr - 3'h1 - s.rec_sel;
		rr = s.rec[rd_idx];
		if (s.rd_pend) begin
			case (s.addr)
				OFS_PASS: n.rdata = {31'h0000_0000, s.unlocked};
				OFS_IMOT: n.rdata = {16'h0000, s.imot};
				OFS_GROUP: n.rdata = {18'h0_0000, s.act_grp, 2'h0, s.src_idx,
					s.src_kind, s.grp_alt, s.grp_man};
				OFS_FORCE: n.rdata = {27'h000_0000, s.fbits, s.force_on};
				OFS_STATUS: n.rdata = {s.unb_pct, 9'h000, block_rev, s.rev_to, s.rev_so,
					block_unb, s.unb_to, s.unb_so, 1'b0};
				OFS_UNB_CNT: n.rdata = {s.unb_tcnt, s.unb_scnt};
				OFS_REV_CNT: n.rdata = {s.rev_tcnt, s.rev_scnt};
				OFS_REV_MEAS: n.rdata = {s.rev_max, s.rev_pct};
				OFS_UNB_MEAS: n.rdata = {s.rev_edly, s.unb_edly, s.unb_max};
				OFS_REC_SEL: n.rdata = {29'h0000_0000, s.rec_sel};
				OFS_REC_VAL: n.rdata = {6'h00, rr.grp, rr.edly, rr.max_val};
				OFS_REC_DATE: n.rdata = rr.date;
				OFS_REC_TOD: n.rdata = rr.tod;
				default: begin
					n.rdata = 32'h0000_0000;
					if (is_grp(s.addr)) begin
						wg = s.addr[5:4];
						case (s.addr[3:2])
							2'h0: n.rdata = {15'h0000, s.grp[wg].inverse_delay_mode,
								s.grp[wg].pickup};
							2'h1: n.rdata = {12'h000, s.grp[wg].fixed_ms};
							2'h2: n.rdata = {12'h000, s.grp[wg].delay_multiplier};
							default: n.rdata = 32'h0000_0000;
						endcase
					end
				end
			endcase
		end

		// Address phase; reads take one wait cycle, writes none
		n.wr_pend = 1'b0;
		n.rd_pend = 1'b0;
		if (hready && hsel && htrans[1]) begin
			n.addr = haddr[7:0];
			n.wr_pend = hwrite;
			n.rd_pend = !hwrite;
		end
	end

	// Single state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			// Settings that power up non-zero
			s.imot <= RST_IMOT;
			for (int i = 0; i < 4; i++) begin
				s.grp[i].pickup <= RST_PICKUP_PCT;
			end
		end else begin
			s <= n;
		end
	end
endmodule

/* File: dv/nsp_checker.sv */
module nsp_checker
	import nsp_pkg::*;
#(
	parameter int TICK_CYC = 4,
	parameter int FORCE_MS = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic motor_starting,
	input wire logic block_unb,
	input wire logic block_rev,
	input wire stage_out_t unb_out,
	input wire stage_out_t rev_out,
	input wire logic force_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rev_run_ff;
	logic [31:0] force_run_ff;
	logic bus_take;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Transfer accepted at this edge
	assign bus_take = hsel && hready && htrans[1];
	// Run lengths kept in counters, since the spans are far too long for repetition
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rev_run_ff <= 32'h0;
			force_run_ff <= 32'h0;
		end else begin
			rev_run_ff <= rev_out.start ? rev_run_ff + 32'h1 : 32'h0;
			force_run_ff <= force_flag ? force_run_ff + 32'h1 : 32'h0;
		end
	end
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	chk_read_wait: assert property (bus_take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
	chk_write_nowait: assert property (bus_take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	chk_unb_blocked: assert property (block_unb [*2] |-> unb_out == '0)
		else $error("blocked unbalance stage active");
	chk_rev_blocked: assert property (block_rev [*2] |-> rev_out == '0)
		else $error("blocked reversal stage active");
	chk_trip_with_start: assert property (unb_out.trip && !force_flag && !$past(force_flag)
		|-> unb_out.start)
		else $error("unbalance trip without start");
	chk_rev_cause: assert property ($rose(rev_out.start) && !force_flag && !$past(force_flag)
		|-> $past(motor_starting))
		else $error("reversal start outside motor start-up");
	chk_rev_delay: assert property ($rose(rev_out.trip) && !force_flag |->
		rev_run_ff >= 99 * TICK_CYC - 2 && rev_run_ff <= 100 * TICK_CYC + 3)
		else $error("reversal trip delay wrong");
	chk_force_expiry: assert property (force_run_ff <= (FORCE_MS + 1) * TICK_CYC + 20)
		else $error("force flag outlived its timeout");
	cover property ($rose(unb_out.trip));
	cover property ($rose(rev_out.trip));
	cover property ($fell(force_flag));
endmodule

bind negative_sequence_protection nsp_checker #(.TICK_CYC(TICK_CYC), .FORCE_MS(FORCE_MS))
	nsp_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.motor_starting(motor_starting), .block_unb(block_unb), .block_rev(block_rev),
	.unb_out(unb_out), .rev_out(rev_out), .force_flag(force_flag));

/* File: dv/tb_top.sv */
module tb_top
	import nsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	localparam int FMS = 20;
	localparam logic RD = 1'b0;
	localparam logic WR = 1'b1;
	logic hclk, hresetn, hwrite, hreadyout, hresp, motor_starting, block_unb, block_rev;
	logic force_flag, rd_ph;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, date_stamp, time_of_day_ms, r;
	logic [7:0] digital_in, virtual_input_n, indicator_signal_n, virtual_output_n;
	seq_meas_t meas;
	stage_out_t unb_out, rev_out;
	logic [63:0] exp_q[$];
	logic [63:0] lr;
	int error_cnt;
	int samples_checked;
	int seed = 32'hC2F79E95;

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	negative_sequence_protection #(.TICK_CYC(TK), .FORCE_MS(FMS))
	negative_sequence_protection_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.meas(meas), .motor_starting(motor_starting), .block_unb(block_unb),
		.block_rev(block_rev), .digital_in(digital_in), .virtual_input_n(virtual_input_n),
		.indicator_signal_n(indicator_signal_n), .virtual_output_n(virtual_output_n),
		.date_stamp(date_stamp), .time_of_day_ms(time_of_day_ms), .unb_out(unb_out),
		.rev_out(rev_out), .force_flag(force_flag));

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Ready is looked at on the falling edge, where it has settled for the next rising one
	task automatic wt();
		@(negedge hclk);
		while (hreadyout !== 1'b1) @(negedge hclk);
		@(posedge hclk);
	endtask

	// One single transfer; a read notes its expected word and mask for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hFFFFFFFF);
		if (!w) exp_q.push_back({m, d});
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		wt();
		rd_ph <= 1'b0;
	endtask

	task automatic mload(input logic [15:0] n2, input logic [15:0] p1, input logic [15:0] av);
		meas <= {n2, p1, av, 1'b1};
		@(posedge hclk);
		meas.valid <= 1'b0;
		@(posedge hclk);
	endtask

	// Trip time measured in cycles, tick phase allowed for
	task automatic trip_in(input int ms);
		int n;
		n = 0;
		while (unb_out.trip !== 1'b1 && n < 9000) begin
			@(negedge hclk);
			n++;
		end
		check(32'(n > ms * TK - 8 && n < ms * TK + 8), 32'h1);
		@(posedge hclk);
	endtask

	// Read data taken when the data phase completes
	always @(negedge hclk) begin
		if (rd_ph && hreadyout) begin
			lr = exp_q.pop_front();
			check(hrdata & lr[63:32], lr[31:0]);
		end
	end

	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		wrap_up();
	end

	initial begin
		hresetn = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		rd_ph = 1'b0;
		meas = '0;
		{motor_starting, block_unb, block_rev} = 3'h0;
		{digital_in, virtual_input_n, indicator_signal_n, virtual_output_n} = 32'h0;
		{date_stamp, time_of_day_ms} = 64'h0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(RD, OFS_IMOT, 32'h64);
		bus(RD, OFS_GRP_BASE, 32'hF);
		bus(WR, OFS_IMOT, 32'h50);
		bus(RD, OFS_IMOT, 32'h64);
		bus(WR, OFS_PASS, PASS_KEY);
		bus(RD, OFS_PASS, 32'h1, 32'h1);
		bus(RD, 8'h28, 32'h0);
		r = $random(seed) & 32'hFFFFF;
		bus(WR, 8'h74, r);
		bus(RD, 8'h74, r);
		$display("test registers done");
		{digital_in, virtual_input_n, indicator_signal_n, virtual_output_n} <= 32'hFFFFFFFF;
		repeat (4) @(posedge hclk);
		for (int k = 0; k < 5; k++) begin
			bus(WR, OFS_GROUP, 32'h9 | (32'(k) << 4));
			bus(RD, OFS_GROUP, (k == 0) ? 32'h1000 : 32'h2000, 32'h3000);
		end
		virtual_output_n <= 8'h00;
		bus(RD, OFS_GROUP, 32'h1000, 32'h3000);
		bus(WR, OFS_GROUP, 32'h0);
		$display("test groups done");
		bus(WR, OFS_GRP_BASE + 8'h04, 32'h5);
		date_stamp <= $random(seed);
		time_of_day_ms <= $random(seed);
		mload(16'h0014, 16'h0064, 16'h0064);
		trip_in(5);
		bus(RD, OFS_STATUS, 32'h6, 32'h6);
		bus(RD, OFS_UNB_CNT, 32'h0001_0001);
		mload(16'h0000, 16'h0064, 16'h0064);
		bus(RD, OFS_STATUS, 32'h0, 32'h6);
		bus(RD, OFS_REC_VAL, 32'h0064_0014);
		bus(RD, OFS_REC_DATE, date_stamp);
		bus(RD, OFS_REC_TOD, time_of_day_ms);
		r = date_stamp;
		date_stamp <= $random(seed);
		bus(WR, OFS_GRP_BASE, 32'h0001_000F);
		bus(WR, OFS_GRP_BASE + 8'h08, 32'h7);
		mload(16'h0014, 16'h0064, 16'h0064);
		trip_in(400);
		mload(16'h0000, 16'h0064, 16'h0064);
		bus(RD, OFS_REC_VAL, 32'h0064_0014, 32'h00FF_FFFF);
		bus(RD, OFS_UNB_MEAS, 32'h0064_0014, 32'h00FF_FFFF);
		bus(WR, OFS_REC_SEL, 32'h1);
		bus(RD, OFS_REC_SEL, 32'h1);
		bus(RD, OFS_REC_DATE, r);
		$display("test unbalance done");
		block_unb <= 1'b1;
		block_rev <= 1'b1;
		motor_starting <= 1'b1;
		mload(16'h0014, 16'h0016, 16'h0064);
		repeat (40) @(posedge hclk);
		bus(RD, OFS_STATUS, 32'h48, 32'h7E);
		bus(RD, OFS_UNB_CNT, 32'h0002_0002);
		bus(RD, OFS_REV_CNT, 32'h0);
		mload(16'h0000, 16'h0064, 16'h0064);
		{block_unb, block_rev} <= 2'h0;
		mload(16'h0009, 16'h000A, 16'h001E);
		while (rev_out.trip !== 1'b1) @(negedge hclk);
		@(posedge hclk);
		bus(RD, OFS_REV_CNT, 32'h0001_0001);
		bus(RD, OFS_REV_MEAS, 32'h5A, 32'hFFFF);
		bus(RD, OFS_UNB_MEAS, 32'h6464_0014);
		motor_starting <= 1'b0;
		$display("test block and reversal done");
		bus(WR, OFS_FORCE, 32'h2);
		bus(RD, OFS_STATUS, 32'h0, 32'h2);
		bus(WR, OFS_FORCE, 32'h1);
		bus(WR, OFS_FORCE, 32'h3);
		bus(RD, OFS_STATUS, 32'h2, 32'h2);
		repeat ((FMS + 2) * TK) @(posedge hclk);
		bus(RD, OFS_STATUS, 32'h0, 32'h2);
		check(32'(force_flag), 32'h0);
		bus(WR, OFS_CLEAR, 32'h3);
		bus(RD, OFS_UNB_CNT, 32'h0);
		bus(RD, OFS_REV_CNT, 32'h0);
		$display("test force and clear done");
		wrap_up();
	end
endmodule
